// >>> sbsd_core.v
// Contract
// - Working register minus operand minus inverted borrow
// - Borrow cleared on negative, else set
// - Memory variant writes back, updates four flags
// - Decrement operand, skip following when zero
// - Skip inserts dummy cycle, two cycles total
// - Nonzero decrement continues in normal sequence
`timescale 1ns/10ps
`include "sbsd_map.vh"

module sbsd_core #(
	parameter DATA_W = 8
) (
	// Clock and reset
	input  wire              clk_sys_i,
	input  wire              rst_i,
	// Instruction issue
	input  wire              op_valid_i,
	input  wire [1:0]        op_code_i,
	output wire              op_ready_o,
	output wire              op_done_o,
	// Data memory operand
	input  wire [DATA_W-1:0] mem_rdata_i,
	output wire              mem_we_o,
	output wire [DATA_W-1:0] mem_wdata_o,
	// Program sequencer
	output wire              skip_o,
	// Datapath state
	output wire [DATA_W-1:0] working_register_o,
	output wire              borrow_flag_o,
	output wire              null_result_flag_o,
	output wire              half_carry_flag_o,
	output wire              signed_wrap_flag_o,
	// Wishbone slave
	input  wire              wb_cyc_i,
	input  wire              wb_stb_i,
	input  wire              wb_we_i,
	input  wire [3:0]        wb_adr_i,
	input  wire [3:0]        wb_sel_i,
	input  wire [31:0]       wb_dat_i,
	output wire [31:0]       wb_dat_o,
	output wire              wb_ack_o
);

	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	localparam [1:0] ST_RUN   = 2'b01;
	localparam [1:0] ST_DUMMY = 2'b10;

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	reg [1:0]        state_reg;
	reg [1:0]        state_next;
	reg [DATA_W-1:0] work_reg;
	reg [DATA_W-1:0] work_next;
	reg              borrow_reg;
	reg              borrow_next;
	reg              zero_reg;
	reg              zero_next;
	reg              half_reg;
	reg              half_next;
	reg              wrap_reg;
	reg              wrap_next;
	reg              ready_reg;
	reg              ready_next;
	reg              done_reg;
	reg              done_next;
	reg              skip_reg;
	reg              skip_next;
	reg              mem_we_reg;
	reg              mem_we_next;
	reg [DATA_W-1:0] mem_wdata_reg;
	reg [DATA_W-1:0] mem_wdata_next;
	reg [7:0]        cnt_reg;
	reg [7:0]        cnt_next;
	reg              ack_reg;
	reg              ack_next;
	reg [31:0]       rdat_reg;
	reg [31:0]       rdat_next;

	// ----------------------------------------------------------------
	// Arithmetic
	// ----------------------------------------------------------------
	wire [DATA_W:0]   diff_full;
	wire [4:0]        diff_half;
	wire [DATA_W-1:0] diff_res;
	wire [DATA_W-1:0] dec_res;
	wire              diff_wrap;
	wire              bus_req;
	wire              bus_wr;
	wire [1:0]        bus_idx;

	assign diff_full = {1'b0, work_reg} - {1'b0, mem_rdata_i} - {{DATA_W{1'b0}}, ~borrow_reg};
	assign diff_half = {1'b0, work_reg[3:0]} - {1'b0, mem_rdata_i[3:0]} - {4'h0, ~borrow_reg};
	assign diff_res  = diff_full[DATA_W-1:0];
	assign diff_wrap = (work_reg[DATA_W-1] ^ mem_rdata_i[DATA_W-1])
		& (work_reg[DATA_W-1] ^ diff_res[DATA_W-1]);
	assign dec_res   = mem_rdata_i - {{(DATA_W-1){1'b0}}, 1'b1};

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// Request seen once; ack rises on the next edge
	assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
	// Write lands on the edge where the master samples ack,
	// so a request dropped before ack leaves the registers alone
	assign bus_wr  = wb_cyc_i & wb_stb_i & ack_reg & wb_we_i & wb_sel_i[0];
	assign bus_idx = wb_adr_i[3:2];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always @*
	begin
		state_next     = state_reg;
		work_next      = work_reg;
		borrow_next    = borrow_reg;
		zero_next      = zero_reg;
		half_next      = half_reg;
		wrap_next      = wrap_reg;
		ready_next     = ready_reg;
		// Pulses default low every cycle
		done_next      = 1'b0;
		skip_next      = 1'b0;
		mem_we_next    = 1'b0;
		mem_wdata_next = mem_wdata_reg;
		cnt_next       = cnt_reg;
		// Software writes first; an instruction in the same cycle wins
		if (bus_wr && bus_idx == `SBSD_IDX_WORK)
			work_next = wb_dat_i[DATA_W-1:0];
		if (bus_wr && bus_idx == `SBSD_IDX_FLAGS)
		begin
			borrow_next = wb_dat_i[`SBSD_FLG_BORROW];
			zero_next   = wb_dat_i[`SBSD_FLG_ZERO];
			half_next   = wb_dat_i[`SBSD_FLG_HALF];
			wrap_next   = wb_dat_i[`SBSD_FLG_WRAP];
		end
		case (state_reg)
			ST_RUN:
			begin
				ready_next = 1'b1;
				if (op_valid_i)
				begin
					case (op_code_i)
						`SBSD_OP_SUB_WORK:
						begin
							done_next   = 1'b1;
							work_next   = diff_res;
							borrow_next = ~diff_full[DATA_W];
							zero_next   = (diff_res == {DATA_W{1'b0}});
							half_next   = ~diff_half[4];
							wrap_next   = diff_wrap;
						end
						`SBSD_OP_SUB_MEM:
						begin
							done_next      = 1'b1;
							mem_we_next    = 1'b1;
							mem_wdata_next = diff_res;
							borrow_next    = ~diff_full[DATA_W];
							zero_next      = (diff_res == {DATA_W{1'b0}});
							half_next      = ~diff_half[4];
							wrap_next      = diff_wrap;
						end
						`SBSD_OP_DEC_SKIP:
						begin
							done_next      = 1'b1;
							mem_we_next    = 1'b1;
							mem_wdata_next = dec_res;
							if (dec_res == {DATA_W{1'b0}})
							begin
								state_next = ST_DUMMY;
								ready_next = 1'b0;
								skip_next  = 1'b1;
								cnt_next   = cnt_reg + 8'h01;
							end
							else
								state_next = ST_RUN;
						end
						// Code zero is a bubble; nothing moves
						default:
							done_next = 1'b0;
					endcase
				end
			end
			ST_DUMMY:
			begin
				// Second cycle ends here
				// Issue refused here; sequencer drops the fetched word
				state_next = ST_RUN;
				ready_next = 1'b1;
			end
			default:
			begin
				state_next = ST_RUN;
				ready_next = 1'b1;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Bus read
	// ----------------------------------------------------------------
	always @*
	begin
		// Read data stands in the ack cycle only
		ack_next  = bus_req;
		rdat_next = 32'h0000_0000;
		if (bus_req && !wb_we_i)
		begin
			case (bus_idx)
				`SBSD_IDX_WORK:
					rdat_next[DATA_W-1:0] = work_reg;
				`SBSD_IDX_FLAGS:
				begin
					rdat_next[`SBSD_FLG_BORROW] = borrow_reg;
					rdat_next[`SBSD_FLG_ZERO]   = zero_reg;
					rdat_next[`SBSD_FLG_HALF]   = half_reg;
					rdat_next[`SBSD_FLG_WRAP]   = wrap_reg;
				end
				`SBSD_IDX_STATUS:
				begin
					rdat_next[`SBSD_STS_DUMMY]                      = state_reg[1];
					rdat_next[`SBSD_STS_CNT_LSB+7:`SBSD_STS_CNT_LSB] = cnt_reg;
				end
				// Unmapped words read as zero
				default:
					rdat_next = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Flip-flops
	// ----------------------------------------------------------------
	// Ready held low in reset; an op_valid_i in the first cycle after reset still executes
	always @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			state_reg     <= ST_RUN;
			work_reg      <= `SBSD_RST_WORK;
			borrow_reg    <= 1'b0;
			zero_reg      <= 1'b0;
			half_reg      <= 1'b0;
			wrap_reg      <= 1'b0;
			ready_reg     <= 1'b0;
			done_reg      <= 1'b0;
			skip_reg      <= 1'b0;
			mem_we_reg    <= 1'b0;
			mem_wdata_reg <= {DATA_W{1'b0}};
			cnt_reg       <= `SBSD_RST_CNT;
			ack_reg       <= 1'b0;
			rdat_reg      <= 32'h0000_0000;
		end
		else
		begin
			state_reg     <= state_next;
			work_reg      <= work_next;
			borrow_reg    <= borrow_next;
			zero_reg      <= zero_next;
			half_reg      <= half_next;
			wrap_reg      <= wrap_next;
			ready_reg     <= ready_next;
			done_reg      <= done_next;
			skip_reg      <= skip_next;
			mem_we_reg    <= mem_we_next;
			mem_wdata_reg <= mem_wdata_next;
			cnt_reg       <= cnt_next;
			ack_reg       <= ack_next;
			rdat_reg      <= rdat_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign op_ready_o         = ready_reg;
	assign op_done_o          = done_reg;
	assign mem_we_o           = mem_we_reg;
	assign mem_wdata_o        = mem_wdata_reg;
	assign skip_o             = skip_reg;
	assign working_register_o = work_reg;
	assign borrow_flag_o      = borrow_reg;
	assign null_result_flag_o = zero_reg;
	assign half_carry_flag_o  = half_reg;
	assign signed_wrap_flag_o = wrap_reg;
	assign wb_dat_o           = rdat_reg;
	assign wb_ack_o           = ack_reg;

endmodule // sbsd_core

// >>> sbsd_core_bench.sv
`timescale 1ns/10ps
module sbsd_core_bench;
	reg         clk_sys_i = 1'b0;
	reg         rst_i = 1'b1;
	reg         op_valid_i = 1'b0;
	reg  [1:0]  op_code_i = 2'h0;
	reg         wb_cyc_i = 1'b0;
	reg         wb_stb_i = 1'b0;
	reg         wb_we_i = 1'b0;
	reg  [3:0]  wb_adr_i = 4'h0;
	reg  [3:0]  wb_sel_i = 4'h1;
	reg  [31:0] wb_dat_i = 32'h0000_0000;
	reg         load_i = 1'b0;
	reg  [7:0]  load_dat_i = 8'h00;
	reg  [31:0] rd;
	integer     num_errors = 0;
	integer     num_checks = 0;
	wire        op_ready_o, op_done_o, mem_we_o, skip_o, wb_ack_o;
	wire        borrow_flag_o, null_result_flag_o, half_carry_flag_o, signed_wrap_flag_o;
	wire [7:0]  mem_rdata_i, mem_wdata_o, working_register_o;
	wire [31:0] wb_dat_o;
	wire [3:0]  flags = {signed_wrap_flag_o, half_carry_flag_o, null_result_flag_o, borrow_flag_o};
	wire [3:0]  hs = {op_done_o, mem_we_o, skip_o, op_ready_o};

	always #2 clk_sys_i = ~clk_sys_i;

	sbsd_core i_dut (.clk_sys_i, .rst_i, .op_valid_i, .op_code_i, .op_ready_o, .op_done_o,
		.mem_rdata_i, .mem_we_o, .mem_wdata_o, .skip_o, .working_register_o, .borrow_flag_o,
		.null_result_flag_o, .half_carry_flag_o, .signed_wrap_flag_o, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
	sbsd_mem_model i_mem (.clk_sys_i, .load_i, .load_dat_i, .mem_we_i(mem_we_o),
		.mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));

	task chk(input [31:0] got, input [31:0] exp);
	begin
		num_checks = num_checks + 1;
		if (got !== exp)
		begin
			num_errors = num_errors + 1;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask

	// Holds the request until ack is sampled
	task wb(input we, input [3:0] adr, input [31:0] dat);
	begin
		@(posedge clk_sys_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		@(posedge clk_sys_i);
		while (wb_ack_o !== 1'b1)
			@(posedge clk_sys_i);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	end
	endtask

	// Second code is offered in the cycle right after the first
	task op(input [1:0] code, input [7:0] m, input [1:0] code2);
	begin
		@(posedge clk_sys_i);
		load_i <= 1'b1;
		load_dat_i <= m;
		@(posedge clk_sys_i);
		load_i <= 1'b0;
		op_valid_i <= 1'b1;
		op_code_i <= code;
		@(posedge clk_sys_i);
		op_valid_i <= (code2 != 2'h0);
		op_code_i <= code2;
		@(posedge clk_sys_i);
		op_valid_i <= 1'b0;
	end
	endtask

	task give_verdict;
	begin
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask

	initial
	begin
		repeat (2000) @(posedge clk_sys_i);
		$display("mismatch at %0t: timeout waiting for tests", $time);
		num_errors = num_errors + 1;
		give_verdict;
	end

	initial
	begin
		repeat (6) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		wb(0, 4'h4, 0);
		chk(rd, 0);
		wb(1, 4'hC, 32'h0000_00AA);
		wb(0, 4'hC, 0);
		chk(rd, 0);
		wb(1, 4'h0, 32'h0000_0010);
		wb(1, 4'h4, 32'h0000_0001);
		op(2'h1, 8'h05, 2'h1);
		chk({hs, working_register_o}, 12'h90B);
		@(posedge clk_sys_i);
		chk({flags, working_register_o}, 12'h506);
		wb(1, 4'h0, 32'h0000_0005);
		op(2'h1, 8'h05, 2'h1);
		chk({flags, working_register_o}, 12'h700);
		@(posedge clk_sys_i);
		chk({flags, working_register_o}, 12'h0FB);
		wb(1, 4'h0, 32'h0000_0080);
		wb(1, 4'h4, 32'h0000_0001);
		op(2'h2, 8'h01, 2'h0);
		chk({hs, mem_wdata_o, working_register_o}, 20'hD_7F80);
		@(posedge clk_sys_i);
		chk(mem_rdata_i, 8'h7F);
		wb(0, 4'h4, 0);
		chk(rd, 32'h0000_0009);
		op(2'h3, 8'h02, 2'h0);
		chk({hs, mem_wdata_o, flags}, 16'hD019);
		op(2'h3, 8'h01, 2'h1);
		chk({hs, mem_wdata_o, flags}, 16'hE009);
		@(posedge clk_sys_i);
		chk({hs, working_register_o}, 12'h180);
		wb(0, 4'h8, 0);
		chk(rd, 32'h0000_0100);
		give_verdict;
	end
endmodule // sbsd_core_bench

bind sbsd_core sbsd_core_checker #(.DATA_W(DATA_W)) i_chk (.clk_sys_i, .rst_i, .op_valid_i,
	.op_code_i, .op_ready_o, .op_done_o, .mem_rdata_i, .mem_we_o, .mem_wdata_o, .skip_o,
	.working_register_o, .borrow_flag_o, .null_result_flag_o, .half_carry_flag_o,
	.signed_wrap_flag_o);

// >>> sbsd_core_checker.sv
`timescale 1ns/10ps
module sbsd_core_checker #(
	parameter DATA_W = 8
) (
	// Clock and reset
	input wire              clk_sys_i,
	input wire              rst_i,
	// Instruction and memory
	input wire              op_valid_i,
	input wire [1:0]        op_code_i,
	input wire              op_ready_o,
	input wire              op_done_o,
	input wire [DATA_W-1:0] mem_rdata_i,
	input wire              mem_we_o,
	input wire [DATA_W-1:0] mem_wdata_o,
	input wire              skip_o,
	// State
	input wire [DATA_W-1:0] working_register_o,
	input wire              borrow_flag_o,
	input wire              null_result_flag_o,
	input wire              half_carry_flag_o,
	input wire              signed_wrap_flag_o
);
	localparam T = DATA_W - 1;
	wire [DATA_W:0] diff = {1'b0, working_register_o} - {1'b0, mem_rdata_i}
		- {{DATA_W{1'b0}}, ~borrow_flag_o};
	wire [4:0] low = {1'b0, working_register_o[3:0]} - {1'b0, mem_rdata_i[3:0]}
		- {4'h0, ~borrow_flag_o};
	wire wrap = (working_register_o[T] ^ mem_rdata_i[T]) & (working_register_o[T] ^ diff[T]);
	wire [T:0] dec = mem_rdata_i - {{T{1'b0}}, 1'b1};
	wire take = op_valid_i && op_ready_o && op_code_i != 2'h0;
	wire [3:0] flags = {signed_wrap_flag_o, half_carry_flag_o, null_result_flag_o, borrow_flag_o};

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	// ----
	// Skip sequence
	// ----
	sequence dummy_cycle;
		skip_o && !op_ready_o;
	endsequence
	sequence resume;
		op_ready_o && !skip_o;
	endsequence

	a_sub_work: assert property (
		take && op_code_i == 2'h1 |=> op_done_o && working_register_o == $past(diff[T:0]))
		else $error("working register result wrong");
	a_borrow_zero: assert property (
		take && op_code_i[1] != op_code_i[0] |=> borrow_flag_o == $past(!diff[DATA_W])
		&& null_result_flag_o == ($past(diff[T:0]) == 0)) else $error("borrow or zero wrong");
	a_mem_sub: assert property (
		take && op_code_i == 2'h2 |=> mem_we_o && mem_wdata_o == $past(diff[T:0])
		&& $stable(working_register_o)) else $error("memory subtract wrong");
	a_mem_flags: assert property (
		take && op_code_i == 2'h2 |=> half_carry_flag_o == $past(!low[4])
		&& signed_wrap_flag_o == $past(wrap)) else $error("half or wrap flag wrong");
	a_dec_write: assert property (
		take && op_code_i == 2'h3 |=> mem_we_o && mem_wdata_o == $past(dec) && $stable(flags))
		else $error("decrement write or flags wrong");
	a_skip_dummy: assert property (
		take && op_code_i == 2'h3 && dec == 0 |=> dummy_cycle ##1 resume)
		else $error("skip dummy cycle wrong");
	a_no_skip: assert property (
		take && op_code_i == 2'h3 && dec != 0 |=> !skip_o && op_ready_o)
		else $error("skip on nonzero decrement");
	a_idle_quiet: assert property (
		!take |=> !op_done_o && !mem_we_o && !skip_o) else $error("pulse without instruction");
endmodule // sbsd_core_checker

// >>> sbsd_map.vh
`ifndef SBSD_MAP_VH
`define SBSD_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SBSD_OFS_WORK      4'h0
`define SBSD_OFS_FLAGS     4'h4
`define SBSD_OFS_STATUS    4'h8

// ----------------------------------------------------------------
// Register word indices
// ----------------------------------------------------------------
`define SBSD_IDX_WORK      2'h0
`define SBSD_IDX_FLAGS     2'h1
`define SBSD_IDX_STATUS    2'h2

// ----------------------------------------------------------------
// Flag field positions
// ----------------------------------------------------------------
`define SBSD_FLG_BORROW    0
`define SBSD_FLG_ZERO      1
`define SBSD_FLG_HALF      2
`define SBSD_FLG_WRAP      3

// ----------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------
`define SBSD_STS_DUMMY     0
`define SBSD_STS_CNT_LSB   8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SBSD_RST_WORK      8'h00
`define SBSD_RST_FLAGS     4'h0
`define SBSD_RST_CNT       8'h00

// ----------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------
`define SBSD_OP_NONE       2'h0
`define SBSD_OP_SUB_WORK   2'h1
`define SBSD_OP_SUB_MEM    2'h2
`define SBSD_OP_DEC_SKIP   2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SBSD_SKIP_CYCLES   2

`endif

// >>> sbsd_mem_model.sv
`timescale 1ns/10ps
// ----
// Data memory cell
// ----
module sbsd_mem_model (
	// Clock
	input  wire       clk_sys_i,
	// Bench preload
	input  wire       load_i,
	input  wire [7:0] load_dat_i,
	// Core side
	input  wire       mem_we_i,
	input  wire [7:0] mem_wdata_i,
	output wire [7:0] mem_rdata_o
);
	reg [7:0] cell_reg;

	// One cell only; address decode is the sequencer's job
	always @(posedge clk_sys_i)
	begin
		if (load_i)
			cell_reg <= load_dat_i;
		else if (mem_we_i)
			cell_reg <= mem_wdata_i;
	end

	assign mem_rdata_o = cell_reg;
endmodule // sbsd_mem_model
